// *** pkg/trf_map.svh ***
// Constants for the request flag decoder and the anticollision logic.
`ifndef TRF_MAP_SVH
`define TRF_MAP_SVH
// Request flag bit positions (bit 1 of the byte is index 0).
`define TRF_RQ_SUBCARRIER 0
`define TRF_RQ_DATA_RATE 1
`define TRF_RQ_INVENTORY 2
`define TRF_RQ_PROTO_EXT 3
`define TRF_RQ_SEL_FAMILY 4
`define TRF_RQ_ADDR_SLOTS 5
`define TRF_RQ_OPTION 6
`define TRF_RQ_RFU 7
// Response flag bit positions.
`define TRF_RS_ERROR 0
// Error codes.
`define TRF_ERR_OPTION 8'h03
`define TRF_ERR_GENERIC 8'h0F
`define TRF_ERR_NO_BLOCK 8'h10
`define TRF_ERR_ALREADY_LOCKED 8'h11
`define TRF_ERR_LOCKED 8'h12
`define TRF_ERR_PROGRAM 8'h13
`define TRF_ERR_LOCK_FAIL 8'h14
// Inventory geometry.
`define TRF_SLOTS_MULTI 5'h10
`define TRF_SLOT_BITS 4
`define TRF_MASK_MAX_BYTES 8
`define TRF_UID_BITS 64
`define TRF_MASK_LEN_MAX 8'h40
`endif

// *** pkg/trf_pkg.sv ***
// Types shared by the request flag and anticollision modules.
package trf_pkg;
    // Error causes reported by the command executor.
    typedef enum logic [2:0] {
        TRF_EC_NONE = 3'h0,
        TRF_EC_OPTION = 3'h1,
        TRF_EC_GENERIC = 3'h2,
        TRF_EC_NO_BLOCK = 3'h3,
        TRF_EC_ALREADY_LOCKED = 3'h4,
        TRF_EC_LOCKED = 3'h5,
        TRF_EC_PROGRAM = 3'h6,
        TRF_EC_LOCK_FAIL = 3'h7
    } trf_err_cause_e;
    // Anticollision slot sequencer states.
    typedef enum logic [2:0] {
        TRF_AC_IDLE = 3'b001,
        TRF_AC_SLOT = 3'b010,
        TRF_AC_DONE = 3'b100
    } trf_ac_state_e;
endpackage

// *** pkg/trf_flags_if.sv ***
// Decoded request flags passed from the decoder to the top module.
`timescale 1ns/1ps
interface trf_flags_if;
    logic two_subcarriers;
    logic high_rate;
    logic inventory;
    logic proto_ext;
    logic select_only;
    logic addressed;
    logic family_field_present;
    logic single_slot_sel;
    logic option_set;
    logic rfu_set;
    modport dec (output two_subcarriers, high_rate, inventory, proto_ext,
        select_only, addressed, family_field_present, single_slot_sel,
        option_set, rfu_set);
    modport use_side (input two_subcarriers, high_rate, inventory,
        proto_ext, select_only, addressed, family_field_present,
        single_slot_sel, option_set, rfu_set);
endinterface

// *** hw/trf_flag_decode.sv ***
// Combinational decoder of the request flag byte.
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_flag_decode (
    // Raw flag byte.
    input wire logic [7:0] req_flags,
    // Decoded flags.
    trf_flags_if.dec fl
);
    // The inventory bit selects what index bits 4 and 5 mean; option and RFU bits do not depend on it.
    always_comb begin
        fl.two_subcarriers = req_flags[`TRF_RQ_SUBCARRIER];
        fl.high_rate = req_flags[`TRF_RQ_DATA_RATE];
        fl.inventory = req_flags[`TRF_RQ_INVENTORY];
        fl.proto_ext = req_flags[`TRF_RQ_PROTO_EXT];
        fl.select_only = !req_flags[`TRF_RQ_INVENTORY]
            && req_flags[`TRF_RQ_SEL_FAMILY];
        fl.addressed = !req_flags[`TRF_RQ_INVENTORY]
            && req_flags[`TRF_RQ_ADDR_SLOTS];
        fl.family_field_present = req_flags[`TRF_RQ_INVENTORY]
            && req_flags[`TRF_RQ_SEL_FAMILY];
        fl.single_slot_sel = req_flags[`TRF_RQ_INVENTORY]
            && req_flags[`TRF_RQ_ADDR_SLOTS];
        fl.option_set = req_flags[`TRF_RQ_OPTION];
        fl.rfu_set = req_flags[`TRF_RQ_RFU];
    end
endmodule

// *** hw/trf_mask_match.sv ***
// Compares slot number and mask against the low bits of the identifier.
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_mask_match (
    // Identifier and received mask.
    input wire logic [63:0] uid,
    input wire logic [63:0] mask,
    input wire logic [6:0] mask_len,
    // Slot selection.
    input wire logic [3:0] slot_num,
    input wire logic single_slot,
    // Result.
    output logic hit
);
    logic [63:0] keep;
    logic [63:0] slot_pos;
    logic [63:0] want;
    logic slot_ok;
    // Per-bit mask of the significant bits, one loop over the identifier.
    for (genvar i = 0; i < `TRF_UID_BITS; i++) begin : g_keep
        assign keep[i] = (7'(i) < mask_len);
    end
    // Slot bits sit directly above the significant mask bits.
    always_comb begin
        want = mask & keep;
        slot_pos = 64'(slot_num) << mask_len;
        slot_ok = single_slot || mask_len > 7'h3c
            || ((uid & (64'h0000_0000_0000_000F << mask_len)) == slot_pos);
        hit = ((uid & keep) == want) && slot_ok;
    end
endmodule

// *** hw/trf_request_flags.sv ***
// Request flag decode, response flag build and inventory anticollision.
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_request_flags (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Received request, from the frame decoder on this clock.
    input wire logic req_valid,
    input wire logic [7:0] req_flags,
    input wire logic [7:0] req_cmd_is_inv,
    input wire logic [7:0] req_mask_len,
    input wire logic [63:0] req_mask,
    input wire logic req_uid_match,
    // Frame events from the reader.
    input wire logic sof_seen,
    input wire logic eof_alone,
    // Tag state and identity.
    input wire logic tag_selected,
    input wire logic [63:0] uid,
    // Error cause from command execution.
    input wire logic err_valid,
    input wire logic [2:0] err_cause,
    // Reply configuration.
    output logic reply_two_sub,
    output logic reply_high_rate,
    output logic family_field_present,
    output logic single_slot_sel,
    // Execution decisions.
    output logic exec_ok,
    output logic opt_reject,
    // Response flag and error code.
    output logic [7:0] resp_flags,
    output logic [7:0] resp_err_code,
    output logic resp_err_valid,
    // Anticollision.
    output logic inv_active,
    output logic [3:0] slot_num,
    output logic inv_answer
);
    // ------------------------------------------------------------
    // Flag decode
    // ------------------------------------------------------------
    trf_flags_if fl ();
    trf_flag_decode u_dec (
        .req_flags(req_flags),
        .fl(fl)
    );

    logic is_inv;
    logic mask_bad;
    assign is_inv = fl.inventory && (req_cmd_is_inv != 8'h00);
    assign mask_bad = req_mask_len > `TRF_MASK_LEN_MAX;

    // Reply mode latched on every request; it governs only our replies.
    always_ff @(posedge mclk) begin
        if (srst) begin
            reply_two_sub <= 1'b0;
            reply_high_rate <= 1'b0;
            family_field_present <= 1'b0;
            single_slot_sel <= 1'b0;
        end else if (req_valid) begin
            reply_two_sub <= fl.two_subcarriers;
            reply_high_rate <= fl.high_rate;
            family_field_present <= fl.family_field_present;
            single_slot_sel <= fl.single_slot_sel;
        end
    end

    // ------------------------------------------------------------
    // Execution decision for non-inventory requests
    // ------------------------------------------------------------
    // Select and addressed together is the illegal combination; it is
    // refused as an unsupported option rather than executed.
    always_ff @(posedge mclk) begin
        if (srst) begin
            exec_ok <= 1'b0;
            opt_reject <= 1'b0;
        end else if (req_valid && !fl.inventory) begin
            opt_reject <= fl.select_only && fl.addressed;
            if (fl.select_only) begin
                exec_ok <= !fl.addressed && tag_selected;
            end else if (fl.addressed) begin
                exec_ok <= req_uid_match;
            end else begin
                exec_ok <= 1'b1;
            end
        end else begin
            exec_ok <= 1'b0;
            opt_reject <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Response flags and error code
    // ------------------------------------------------------------
    logic [7:0] next_code;
    always_comb begin
        unique case (err_cause)
            3'h1: next_code = `TRF_ERR_OPTION;
            3'h3: next_code = `TRF_ERR_NO_BLOCK;
            3'h4: next_code = `TRF_ERR_ALREADY_LOCKED;
            3'h5: next_code = `TRF_ERR_LOCKED;
            3'h6: next_code = `TRF_ERR_PROGRAM;
            3'h7: next_code = `TRF_ERR_LOCK_FAIL;
            default: next_code = `TRF_ERR_GENERIC;
        endcase
    end

    // A zero cause with err_valid still reports the generic code, so a
    // reserved value can never leave the block.
    always_ff @(posedge mclk) begin
        if (srst) begin
            resp_flags <= 8'h00;
            resp_err_code <= 8'h00;
            resp_err_valid <= 1'b0;
        end else if (err_valid || opt_reject) begin
            resp_flags <= 8'h01;
            resp_err_code <= opt_reject ? `TRF_ERR_OPTION : next_code;
            resp_err_valid <= 1'b1;
        end else if (req_valid) begin
            resp_flags <= 8'h00;
            resp_err_code <= 8'h00;
            resp_err_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Anticollision slot sequencer
    // ------------------------------------------------------------
    trf_pkg::trf_ac_state_e ac_state;
    logic slot_hit;
    logic [63:0] mask_q;
    logic [6:0] len_q;
    logic single_q;

    // Mask bits arrive low bit first, so the word is already LSB-aligned
    // and the zero padding at the top is ignored by the length.
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_q <= 64'h0000_0000_0000_0000;
            len_q <= 7'h00;
            single_q <= 1'b0;
        end else if (req_valid && is_inv && !mask_bad) begin
            mask_q <= req_mask;
            len_q <= req_mask_len[6:0];
            single_q <= fl.single_slot_sel;
        end
    end

    trf_mask_match u_match (
        .uid(uid),
        .mask(mask_q),
        .mask_len(len_q),
        .slot_num(slot_num),
        .single_slot(single_q),
        .hit(slot_hit)
    );

    // New request takes priority: a start of frame ends the sequence.
    always_ff @(posedge mclk) begin
        if (srst) begin
            ac_state <= trf_pkg::TRF_AC_IDLE;
            slot_num <= 4'h0;
        end else if (req_valid) begin
            slot_num <= 4'h0;
            ac_state <= (is_inv && !mask_bad) ? trf_pkg::TRF_AC_SLOT
                : trf_pkg::TRF_AC_IDLE;
        end else if (sof_seen) begin
            ac_state <= trf_pkg::TRF_AC_IDLE;
        end else begin
            unique case (ac_state)
                trf_pkg::TRF_AC_IDLE: begin
                    slot_num <= slot_num;
                end
                trf_pkg::TRF_AC_SLOT: begin
                    if (eof_alone) begin
                        if (!single_q && slot_num != 4'hF) begin
                            slot_num <= slot_num + 4'h1;
                        end else begin
                            ac_state <= trf_pkg::TRF_AC_DONE;
                        end
                    end
                end
                trf_pkg::TRF_AC_DONE: begin
                    slot_num <= slot_num;
                end
                default: ac_state <= trf_pkg::TRF_AC_IDLE;
            endcase
        end
    end

    // Slot entry strobe, one cycle per slot entered; the match is tested at the answer.
    logic slot_entry;
    always_ff @(posedge mclk) begin
        if (srst) begin
            slot_entry <= 1'b0;
        end else begin
            slot_entry <= (req_valid && is_inv && !mask_bad)
                || (ac_state == trf_pkg::TRF_AC_SLOT && eof_alone
                    && !sof_seen && !single_q && slot_num != 4'hF);
        end
    end

    // Registered answer and activity; a frame start in the same cycle blocks the answer but not the activity.
    always_ff @(posedge mclk) begin
        if (srst) begin
            inv_answer <= 1'b0;
            inv_active <= 1'b0;
        end else begin
            inv_answer <= slot_entry && slot_hit && !sof_seen
                && ac_state == trf_pkg::TRF_AC_SLOT;
            inv_active <= ac_state == trf_pkg::TRF_AC_SLOT;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Every property here lives on mclk and is quiet during reset.
    default clocking chk_clk @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Response flag byte and error codes.
    resp_rfu_zero_a: assert property (
        resp_flags[7:1] == 7'h00)
        else $error("response reserved bits not zero");

    err_flag_code_a: assert property (
        resp_flags[0] |-> resp_err_code inside {8'h03, 8'h0F, 8'h10,
        8'h11, 8'h12, 8'h13, 8'h14})
        else $error("error flag with reserved code");

    err_sets_flag_a: assert property (
        err_valid |=> resp_flags[0] && resp_err_valid)
        else $error("error flag not raised");

    clear_flag_a: assert property (
        req_valid && !err_valid && !opt_reject
        |=> resp_flags == 8'h00 && !resp_err_valid)
        else $error("error flag not cleared by a clean request");

    opt_code_a: assert property (
        opt_reject |=> resp_flags[0] && resp_err_code == 8'h03)
        else $error("refused flag pair without option code");

    lock_code_a: assert property (
        err_valid && !opt_reject && err_cause == 3'h4
        |=> resp_err_code == 8'h11)
        else $error("wrong already-locked code");

    prog_code_a: assert property (
        err_valid && !opt_reject && err_cause == 3'h6
        |=> resp_err_code == 8'h13)
        else $error("wrong programming failure code");

    // Flag decode and execution decision.
    reply_mode_a: assert property (
        req_valid |=> reply_high_rate == $past(req_flags[1])
        && reply_two_sub == $past(req_flags[0]))
        else $error("reply mode not latched");

    slot_mode_a: assert property (
        req_valid |=> family_field_present
        == ($past(req_flags[2]) && $past(req_flags[4]))
        && single_slot_sel == ($past(req_flags[2]) && $past(req_flags[5])))
        else $error("inventory parameters not latched");

    inv_no_exec_a: assert property (
        req_valid && req_flags[2] |=> !exec_ok && !opt_reject)
        else $error("inventory request took the execution path");

    select_gate_a: assert property (
        req_valid && !req_flags[2] && req_flags[4] && !tag_selected
        |=> !exec_ok)
        else $error("select-only executed while unselected");

    addr_gate_a: assert property (
        req_valid && !req_flags[2] && !req_flags[4] && req_flags[5]
        |=> exec_ok == $past(req_uid_match))
        else $error("addressed request ignored identifier match");

    // Anticollision slot sequence.
    slot_restart_a: assert property (
        req_valid |=> slot_num == 4'h0)
        else $error("slot not restarted");

    slot_step_a: assert property (
        ac_state == trf_pkg::TRF_AC_SLOT && eof_alone && !sof_seen
        && !req_valid && !single_q && slot_num != 4'hF
        |=> slot_num == $past(slot_num) + 4'h1)
        else $error("slot did not advance");

    last_slot_a: assert property (
        ac_state == trf_pkg::TRF_AC_SLOT && eof_alone && !sof_seen
        && !req_valid && (single_q || slot_num == 4'hF)
        |=> ac_state == trf_pkg::TRF_AC_DONE && !slot_entry)
        else $error("sequence ran past its last slot");

    sof_abort_a: assert property (
        sof_seen && !req_valid |=> ac_state == trf_pkg::TRF_AC_IDLE
        ##1 !inv_answer)
        else $error("anticollision not abandoned");

    answer_hit_a: assert property (
        inv_answer |-> $past(slot_hit) && $past(slot_entry))
        else $error("answer outside matching slot");

    answer_slot_a: assert property (
        inv_answer |-> inv_active)
        else $error("answer while no slot sequence runs");

    // Main scenarios the bench is meant to reach.
    inv_cov_c: cover property (inv_answer);
    slot_walk_c: cover property (slot_num == 4'hF);
    abort_c: cover property (inv_active && sof_seen);
    refuse_c: cover property (opt_reject);
    fail_code_c: cover property (resp_flags[0] && resp_err_code == 8'h14);
endmodule

// *** test/trf_reader_model.sv ***
// Reader model that issues decoded requests and frame events to the tag.
`timescale 1ns/1ps
module trf_reader_model (
    // Clock.
    input wire logic mclk,
    // Decoded request.
    output logic req_valid,
    output logic [7:0] req_flags,
    output logic [7:0] req_cmd_is_inv,
    output logic [7:0] req_mask_len,
    output logic [63:0] req_mask,
    // Frame events.
    output logic sof_seen,
    output logic eof_alone
);
    // Idle levels at time zero.
    initial begin
        req_valid = 1'b0;
        req_flags = 8'h00;
        req_cmd_is_inv = 8'h00;
        req_mask_len = 8'h00;
        req_mask = '0;
        sof_seen = 1'b0;
        eof_alone = 1'b0;
    end

    // One request; raw lets a bench scenario keep select with address.
    task automatic send_req(input logic [7:0] flags, input logic inv,
            input logic [7:0] len, input logic [63:0] mask, input logic raw);
        logic [7:0] f;
        logic [63:0] m;
        f = flags & 8'h37;
        if (!raw && !f[2] && f[4]) f[5] = 1'b0;
        m = (len >= 8'h40) ? '1 : ((64'h1 << len) - 64'h1);
        @(negedge mclk);
        req_valid <= 1'b1;
        req_flags <= f;
        req_cmd_is_inv <= inv ? 8'h01 : 8'h00;
        req_mask_len <= len;
        req_mask <= mask & m;
        @(negedge mclk);
        // Fields go stale after the strobe, so show their inverse.
        req_valid <= 1'b0;
        req_flags <= ~f;
        req_cmd_is_inv <= ~req_cmd_is_inv;
        req_mask_len <= ~len;
        req_mask <= ~(mask & m);
    endtask

    // One frame event pulse, then room for a tag answer to finish.
    task automatic pulse(input logic sof);
        @(negedge mclk);
        if (sof) sof_seen <= 1'b1; else eof_alone <= 1'b1;
        @(negedge mclk);
        sof_seen <= 1'b0;
        eof_alone <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for request flags, error codes and inventory slots.
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic req_valid, sof_seen, eof_alone;
    logic [7:0] req_flags, req_cmd_is_inv, req_mask_len;
    logic [63:0] req_mask;
    logic req_uid_match = 1'b0;
    logic tag_selected = 1'b0;
    logic [63:0] uid = '0;
    logic err_valid = 1'b0;
    logic [2:0] err_cause = 3'h0;
    logic reply_two_sub, reply_high_rate, family_field_present;
    logic single_slot_sel, exec_ok, opt_reject, resp_err_valid;
    logic inv_active, inv_answer, prev_err;
    logic [7:0] resp_flags, resp_err_code;
    logic [3:0] slot_num;
    logic [15:0] notes [$];
    logic [7:0] codes [8] = '{8'h0F, 8'h03, 8'h0F, 8'h10, 8'h11, 8'h12,
        8'h13, 8'h14};
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    // Half-period toggle gives the 40 MHz clock.
    always #12.5 mclk = ~mclk;

    trf_reader_model trf_reader_model_i (.mclk(mclk), .req_valid(req_valid),
        .req_flags(req_flags), .req_cmd_is_inv(req_cmd_is_inv),
        .req_mask_len(req_mask_len), .req_mask(req_mask),
        .sof_seen(sof_seen), .eof_alone(eof_alone));

    trf_request_flags trf_request_flags_i (.mclk(mclk), .srst(srst),
        .req_valid(req_valid), .req_flags(req_flags),
        .req_cmd_is_inv(req_cmd_is_inv), .req_mask_len(req_mask_len),
        .req_mask(req_mask), .req_uid_match(req_uid_match),
        .sof_seen(sof_seen), .eof_alone(eof_alone),
        .tag_selected(tag_selected), .uid(uid), .err_valid(err_valid),
        .err_cause(err_cause), .reply_two_sub(reply_two_sub),
        .reply_high_rate(reply_high_rate),
        .family_field_present(family_field_present),
        .single_slot_sel(single_slot_sel), .exec_ok(exec_ok),
        .opt_reject(opt_reject), .resp_flags(resp_flags),
        .resp_err_code(resp_err_code), .resp_err_valid(resp_err_valid),
        .inv_active(inv_active), .slot_num(slot_num),
        .inv_answer(inv_answer));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic note(input logic [7:0] kind, input logic [7:0] val);
        notes.push_back({kind, val});
    endtask

    // An event with nothing queued is compared against an impossible note.
    task automatic take(input logic [15:0] seen);
        check(seen, notes.size() > 0 ? notes.pop_front() : 16'hFFFF);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Expected slot hit: slot bits sit above the significant mask bits.
    function automatic logic hit(input logic [63:0] id, input logic [63:0] mk,
            input logic [7:0] len, input int s, input logic one);
        logic [63:0] m;
        m = (len >= 8'h40) ? '1 : ((64'h1 << len) - 64'h1);
        if (((id ^ mk) & m) != 64'h0) return 1'b0;
        if (one) return s == 0;
        if (len > 8'h3C) return 1'b1;
        return ((id >> len) & 64'hf) == 64'(s);
    endfunction

    // A plain non-addressed request that every tag executes.
    task automatic clean();
        note(8'h02, 8'h02);
        trf_reader_model_i.send_req(8'h00, 1'b0, 8'h00, '0, 1'b0);
        repeat (3) @(negedge mclk);
        check({resp_flags, 7'h0, resp_err_valid}, 16'h0000);
    endtask

    // One inventory; stop is the slot where a new frame start cuts in.
    task automatic inv_run(input logic one, input logic fam,
            input logic [7:0] len, input logic [63:0] mk, input int stop);
        logic [7:0] f;
        logic live;
        logic gone;
        f = {2'b00, one, fam, 4'b0100} | 8'($urandom_range(3));
        live = len <= 8'h40;
        gone = 1'b0;
        if (live && hit(uid, mk, len, 0, one)) note(8'h01, 8'h00);
        trf_reader_model_i.send_req(f, 1'b1, len, mk, 1'b0);
        repeat (3) @(negedge mclk);
        check({family_field_present, single_slot_sel}, {fam, one});
        check({reply_two_sub, reply_high_rate}, {f[0], f[1]});
        check(inv_active, live);
        for (int s = 1; s <= (one ? 2 : 16); s++) begin
            gone |= (s == stop);
            if (live && !gone && s < 16 && hit(uid, mk, len, s, one))
                note(8'h01, 8'(s));
            trf_reader_model_i.pulse(s == stop);
            if (live && !gone && s < 16 && !one) check(slot_num, s);
        end
        check(inv_active, 1'b0);
    endtask

    // Result watcher: every output event takes the oldest note.
    always @(negedge mclk) begin
        if (!srst) begin
            if (inv_answer) take({8'h01, 4'h0, slot_num});
            if (exec_ok || opt_reject)
                take({8'h02, 6'h00, exec_ok, opt_reject});
            if (resp_err_valid && !prev_err) begin
                take({8'h03, resp_err_code});
                check(resp_flags, 8'h01);
            end
        end
        prev_err = resp_err_valid;
    end

    // Hang guard: the whole sequence needs well under 4000 cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] f;
        logic [1:0] v;
        logic [7:0] len;
        logic [63:0] mk;
        void'($urandom(32'h6a3a_1fd2));
        repeat (8) @(negedge mclk);
        check({resp_flags, resp_err_code, slot_num, inv_answer, inv_active,
            exec_ok, opt_reject, resp_err_valid}, 32'h0000_0000);
        srst <= 1'b0;
        // Selection and addressing table, including the refused pair.
        for (int i = 0; i < 8; i++) begin
            f = 8'($urandom);
            v = 2'($urandom_range(3));
            tag_selected <= v[0];
            req_uid_match <= v[1];
            // The pair survives only when the model is told to keep it raw;
            // otherwise the reader drops the address and select rules.
            if (i[0] && i[1] && i[2]) note(8'h02, 8'h01);
            else if (i[0] ? v[0] : (i[1] ? v[1] : 1'b1)) note(8'h02, 8'h02);
            if (i[0] && i[1] && i[2]) note(8'h03, 8'h03);
            trf_reader_model_i.send_req({f[7:6], i[1], i[0], f[3], 1'b0,
                f[1:0]}, 1'b0, 8'h00, '0, i[2]);
            repeat (3) @(negedge mclk);
            check({reply_two_sub, reply_high_rate}, {f[0], f[1]});
        end
        clean();
        // Every error cause, each followed by a clearing request.
        for (int c = 0; c < 8; c++) begin
            note(8'h03, codes[c]);
            err_cause <= 3'(c);
            err_valid <= 1'b1;
            @(negedge mclk);
            err_valid <= 1'b0;
            repeat (3) @(negedge mclk);
            clean();
        end
        // Inventories: length bounds, a miss, single slot, an abort.
        for (int k = 0; k < 12; k++) begin
            uid = {$urandom, $urandom};
            len = (k == 0) ? 8'h00 : (k == 1) ? 8'h40 : (k == 2) ? 8'h41 :
                (k == 3) ? 8'h14 : 8'($urandom_range(60));
            mk = uid ^ ({$urandom, $urandom} << len) ^ 64'(k == 3);
            inv_run(k == 4 || k == 5, 1'($urandom_range(1)), len, mk,
                (k == 6) ? 5 : 99);
        end
        repeat (5) @(negedge mclk);
        check(notes.size(), 0);
        report_and_stop();
    end
endmodule
